//--- bcm_pkg.sv
// Constants, types and carriers of the boot, clock and reset manager
// Assumes one 200 MHz system clock; all rates given as clock enables
`default_nettype none
package bcm_pkg;
   localparam int CLK_MHZ = 200;
   localparam int POR_SETTLE_NS = 1000;
   localparam int POR_SETTLE_CYC = (POR_SETTLE_NS * CLK_MHZ + 999) / 1000;
   localparam int RST_STRETCH_NS = 500;
   localparam int RST_STRETCH_CYC = (RST_STRETCH_NS * CLK_MHZ + 999) / 1000;
   localparam int SOFT_RST_NS = 50;
   localparam int SOFT_RST_CYC = (SOFT_RST_NS * CLK_MHZ + 999) / 1000;
   localparam int OSC_START_US = 64;
   localparam int OSC_START_CYC = OSC_START_US * CLK_MHZ;
   localparam logic [31:0] RESET_ADDR = 32'h8000_0000;
   localparam int NOSC = 3;
   localparam int OSC32 = 2;
   localparam int NPLL = 2;
   localparam int PRE_W = 8;
   localparam int GDIV_W = 8;
   localparam int CNT_W = 16;
   // Bit positions in the vector of synchronised pins
   localparam int A_RC = 0;
   localparam int A_OSC = 1;
   localparam int A_PLL = 4;
   localparam int A_LOCK = 6;
   localparam int A_IRQ = 8;
   localparam int A_BOD = 9;
   localparam int A_EXT = 10;
   localparam int A_PWR = 11;
   localparam int NASYNC = 12;
   // Reset cause bits
   localparam int RC_POR = 0;
   localparam int RC_EXT = 1;
   localparam int RC_WDT = 2;
   localparam int RC_BOD = 3;
   localparam int RC_SOFT = 4;
   localparam int NRC = 5;

   typedef enum logic [1:0] {
      MSEL_SLOW = 2'h0,
      MSEL_OSC0 = 2'h1,
      MSEL_PLL0 = 2'h2
   } bcm_msel_e;

   typedef enum logic [3:0] {
      ST_POR = 4'h1,
      ST_RST = 4'h2,
      ST_RUN = 4'h4,
      ST_SLEEP = 4'h8
   } bcm_state_e;

   typedef struct packed {
      logic en;
      logic [2:0] sel;
   } bcm_div_s;

   typedef struct packed {
      logic [NOSC-1:0] osc_en;
      logic [NPLL-1:0] pll_en;
      logic [NPLL-1:0] pll_ref;
      logic [NPLL-1:0][7:0] pll_mul;
      bcm_msel_e main_sel;
      bcm_div_s cpu_div;
      bcm_div_s pba_div;
      bcm_div_s pbb_div;
   } bcm_cfg_s;

   typedef struct packed {
      logic stop_cpu;
      logic stop_pba;
      logic stop_pbb;
      logic stop_osc;
      logic stop_pll;
   } bcm_sleep_s;

   typedef struct packed {
      logic en;
      logic [1:0] src;
      logic [GDIV_W-1:0] div;
   } bcm_gclk_s;

   typedef struct packed {
      logic [NOSC-1:0] osc_rdy;
      logic [NPLL-1:0] pll_ok;
   } bcm_status_s;

   localparam bcm_cfg_s CFG_RST = '0;
endpackage
`default_nettype wire

//--- bcm_manager.sv
// Boot sequencing, synchronous clock enables, gating, sleep and resets
// Assumes clock pins run well below half of clock_i; config from same clock
`timescale 1ns/1ps
`default_nettype none
// Function
// - Hold system in reset until power stable, then clock from RC
// - After start-up PLLs off, all module clocks on, nothing divided
// - After reset release the CPU fetches from flash start address
// - Three synchronous domains: CPU/high-speed bus, peripheral A, B
// - Each domain divider changes while running, no peripheral halt
// - Every module has its own gateable clock
// - Sleep stops selected clocks and oscillators; interrupt wakes
// - Gather reset sources, make hard and soft resets, record cause
// - Each PLL takes either fast oscillator as reference
// - Generic clocks, asynchronous to domains, finely divisible
// - 32 kHz oscillator clocks the real-time counter
// - Oscillator output blocked during its start-up interval
// - PLL clock blocked while PLL unlocked
// - Main clock defaults to slow RC clock after reset
module bcm_manager #(
   parameter int NHSB = 4,
   parameter int NPBA = 8,
   parameter int NPBB = 4,
   parameter int NGCLK = 2,
   parameter int OSC_START = bcm_pkg::OSC_START_CYC
) (
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic power_ok_i,
   input wire logic ext_resetn_i,
   input wire logic bod_reset_i,
   input wire logic wdt_reset_i,
   input wire logic soft_reset_i,
   input wire logic rc_clk_i,
   input wire logic [bcm_pkg::NOSC-1:0] osc_clk_i,
   input wire logic [bcm_pkg::NPLL-1:0] pll_clk_i,
   input wire logic [bcm_pkg::NPLL-1:0] pll_lock_i,
   input wire logic ext_irq_i,
   input wire logic irq_i,
   input wire logic sleep_i,
   input wire bcm_pkg::bcm_sleep_s sleep_cfg_i,
   input wire logic cfg_wr_i,
   input wire bcm_pkg::bcm_cfg_s cfg_i,
   input wire logic [NHSB-1:0] hsb_mask_i,
   input wire logic [NPBA-1:0] pba_mask_i,
   input wire logic [NPBB-1:0] pbb_mask_i,
   input wire bcm_pkg::bcm_gclk_s [NGCLK-1:0] gclk_cfg_i,
   input wire logic cause_clr_i,
   output logic hard_resetn_o,
   output logic soft_resetn_o,
   output logic fetch_o,
   output logic [31:0] boot_addr_o,
   output logic cpu_clk_en_o,
   output logic [NHSB-1:0] hsb_clk_en_o,
   output logic [NPBA-1:0] pba_clk_en_o,
   output logic [NPBB-1:0] pbb_clk_en_o,
   output logic [NGCLK-1:0] gclk_o,
   output logic rtc_tick_o,
   output logic [bcm_pkg::NOSC-1:0] osc_en_o,
   output logic [bcm_pkg::NPLL-1:0] pll_en_o,
   output logic [bcm_pkg::NPLL-1:0] pll_ref_o,
   output logic [bcm_pkg::NPLL-1:0][7:0] pll_mul_o,
   output bcm_pkg::bcm_status_s status_o,
   output logic [bcm_pkg::NRC-1:0] reset_cause_o
);
   import bcm_pkg::*;
   localparam int OW = $clog2(OSC_START + 1);
   localparam logic [OW-1:0] OSC_LAST = OW'(OSC_START);
   localparam logic [CNT_W-1:0] POR_LAST = CNT_W'(POR_SETTLE_CYC - 1);
   localparam logic [CNT_W-1:0] RST_LAST = CNT_W'(RST_STRETCH_CYC - 1);
   localparam logic [CNT_W-1:0] SOFT_LEN = CNT_W'(SOFT_RST_CYC);
   if (OSC_START < 8 || NHSB < 1 || NPBA < 1 || NPBB < 1 || NGCLK < 1)
      $error("bcm_manager: parameter out of range");
   function automatic logic tap(input bcm_div_s d,
                                input logic [PRE_W-1:0] p);
      logic [PRE_W-1:0] m;
      m = ~({PRE_W{1'b1}} << ({1'b0, d.sel} + 4'h1));
      tap = !d.en || ((p & m) == m);
   endfunction
   logic [NASYNC-1:0] s1_reg, s2_reg, s3_reg;
   bcm_state_e state_reg, state_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next, soft_reg, soft_next;
   bcm_cfg_s cfg_reg, cfg_next;
   bcm_sleep_s slp_reg;
   logic [NHSB-1:0] hsb_mask_reg;
   logic [NPBA-1:0] pba_mask_reg;
   logic [NPBB-1:0] pbb_mask_reg;
   logic [PRE_W-1:0] pre_reg;
   logic [OW-1:0] osc_cnt_reg [NOSC];
   logic [NOSC-1:0] osc_on, osc_rdy, osc_t;
   logic [NPLL-1:0] pll_on, pll_ok, pll_t;
   logic [NRC-1:0] cause_evt, cause_reg;
   // Pins pass two flops; the third only feeds edge detection
   always_ff @(posedge clock_i) begin
      s1_reg <= {power_ok_i, ext_resetn_i, bod_reset_i, ext_irq_i,
                 pll_lock_i, pll_clk_i, osc_clk_i, rc_clk_i};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
   end
   wire logic [NASYNC-1:0] edge_w = s2_reg & ~s3_reg;
   wire logic pwr_s = s2_reg[A_PWR];
   wire logic [NPLL-1:0] lock_s = s2_reg[A_LOCK +: NPLL];
   wire logic hard_src = !s2_reg[A_EXT] || s2_reg[A_BOD] || wdt_reset_i;
   wire logic wake = irq_i || s2_reg[A_IRQ];
   wire logic sleeping = state_reg == ST_SLEEP;
   wire logic active = state_reg == ST_RUN || sleeping;
   wire logic act_next = state_next == ST_RUN || state_next == ST_SLEEP;
   wire logic clocks_up = state_reg != ST_POR;
   wire logic stop_osc = sleeping && slp_reg.stop_osc;
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg + 16'h1;
      case (state_reg)
         ST_POR: if (cnt_reg == POR_LAST) begin
            state_next = ST_RST;
            cnt_next = '0;
         end
         ST_RST: if (hard_src) begin
            cnt_next = '0;
         end else if (cnt_reg == RST_LAST) begin
            state_next = ST_RUN;
         end
         ST_RUN: if (sleep_i) begin
            state_next = ST_SLEEP;
         end
         ST_SLEEP: if (wake) begin
            state_next = ST_RUN;
         end
         default: state_next = ST_POR;
      endcase
      if (!pwr_s) begin
         state_next = ST_POR;
         cnt_next = '0;
      end else if (hard_src && active) begin
         state_next = ST_RST;
         cnt_next = '0;
      end
   end
   // Soft reset leaves configuration alone and records its cause as RC_SOFT
   assign soft_next = !act_next ? '0 :
                      (soft_reset_i && state_reg == ST_RUN) ? SOFT_LEN :
                      (soft_reg != '0) ? soft_reg - 16'h1 : '0;
   wire logic por_exit = state_reg == ST_POR && state_next == ST_RST;
   wire logic hard_in = active && state_next == ST_RST;
   always_comb begin
      cause_evt = '0;
      cause_evt[RC_POR] = por_exit;
      cause_evt[RC_EXT] = hard_in && !s2_reg[A_EXT];
      cause_evt[RC_BOD] = hard_in && s2_reg[A_BOD];
      cause_evt[RC_WDT] = hard_in && wdt_reset_i;
      cause_evt[RC_SOFT] = soft_reset_i && state_reg == ST_RUN && act_next;
   end
   // Configuration resets to slow clock, PLLs off, no division; the
   // 32 kHz oscillator survives every reset except power-on
   always_comb begin
      cfg_next = cfg_reg;
      if (!active) begin
         cfg_next = CFG_RST;
         cfg_next.osc_en[OSC32] = clocks_up && cfg_reg.osc_en[OSC32];
      end else if (cfg_wr_i) begin
         cfg_next = cfg_i;
      end
   end
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         state_reg <= ST_POR;
         cnt_reg <= '0;
         soft_reg <= '0;
         cfg_reg <= CFG_RST;
         cause_reg <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         soft_reg <= soft_next;
         cfg_reg <= cfg_next;
         cause_reg <= (|cause_evt) ? cause_evt :
                      cause_clr_i ? '0 : cause_reg;
      end
   end
   // Module masks open on power-on and hard reset, not on soft reset; software gates them later
   always_ff @(posedge clock_i) begin
      if (!resetn_i || !active) begin
         hsb_mask_reg <= '1;
         pba_mask_reg <= '1;
         pbb_mask_reg <= '1;
      end else if (cfg_wr_i) begin
         hsb_mask_reg <= hsb_mask_i;
         pba_mask_reg <= pba_mask_i;
         pbb_mask_reg <= pbb_mask_i;
      end
   end
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         slp_reg <= '0;
      end else if (state_reg == ST_RUN && sleep_i) begin
         slp_reg <= sleep_cfg_i;
      end
   end
   // Start-up counters mask each oscillator until it has settled
   for (genvar i = 0; i < NOSC; i++) begin : g_osc
      assign osc_on[i] = cfg_reg.osc_en[i] && (i == OSC32 || !stop_osc);
      assign osc_rdy[i] = osc_cnt_reg[i] == OSC_LAST;
      assign osc_t[i] = edge_w[A_OSC + i] && osc_rdy[i];
      always_ff @(posedge clock_i) begin
         if (!resetn_i || !osc_on[i]) begin
            osc_cnt_reg[i] <= '0;
         end else if (!osc_rdy[i]) begin
            osc_cnt_reg[i] <= osc_cnt_reg[i] + OW'(1);
         end
      end
   end
   for (genvar i = 0; i < NPLL; i++) begin : g_pll
      assign pll_on[i] = cfg_reg.pll_en[i] &&
                         !(sleeping && slp_reg.stop_pll);
      assign pll_ok[i] = pll_on[i] && lock_s[i] &&
                         osc_rdy[cfg_reg.pll_ref[i]];
      assign pll_t[i] = edge_w[A_PLL + i] && pll_ok[i];
   end
   wire logic main_t = cfg_reg.main_sel == MSEL_OSC0 ? osc_t[0] :
                       cfg_reg.main_sel == MSEL_PLL0 ? pll_t[0] :
                       edge_w[A_RC];
   wire logic cpu_t = main_t && tap(cfg_reg.cpu_div, pre_reg) &&
                      clocks_up && !(sleeping && slp_reg.stop_cpu);
   wire logic pba_t = main_t && tap(cfg_reg.pba_div, pre_reg) &&
                      clocks_up && !(sleeping && slp_reg.stop_pba);
   wire logic pbb_t = main_t && tap(cfg_reg.pbb_div, pre_reg) &&
                      clocks_up && !(sleeping && slp_reg.stop_pbb);
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         pre_reg <= '0;
         cpu_clk_en_o <= 1'b0;
         hsb_clk_en_o <= '0;
         pba_clk_en_o <= '0;
         pbb_clk_en_o <= '0;
      end else begin
         pre_reg <= pre_reg + PRE_W'(main_t);
         cpu_clk_en_o <= cpu_t;
         hsb_clk_en_o <= {NHSB{cpu_t}} & hsb_mask_reg;
         pba_clk_en_o <= {NPBA{pba_t}} & pba_mask_reg;
         pbb_clk_en_o <= {NPBB{pbb_t}} & pbb_mask_reg;
      end
   end
   // Generic clocks divide a source by 2*(div+1)
   wire logic [3:0] gsrc = {pll_t, osc_t[1:0]};
   for (genvar g = 0; g < NGCLK; g++) begin : g_gclk
      logic [GDIV_W-1:0] gcnt_reg;
      always_ff @(posedge clock_i) begin
         if (!resetn_i || !gclk_cfg_i[g].en) begin
            gcnt_reg <= '0;
            gclk_o[g] <= 1'b0;
         end else if (gsrc[gclk_cfg_i[g].src]) begin
            gcnt_reg <= gcnt_reg == gclk_cfg_i[g].div ? '0 :
                        gcnt_reg + GDIV_W'(1);
            gclk_o[g] <= gclk_o[g] ^ (gcnt_reg == gclk_cfg_i[g].div);
         end
      end
   end
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         hard_resetn_o <= 1'b0;
         soft_resetn_o <= 1'b0;
         fetch_o <= 1'b0;
         rtc_tick_o <= 1'b0;
         osc_en_o <= '0;
         pll_en_o <= '0;
         pll_ref_o <= '0;
         pll_mul_o <= '0;
         status_o <= '0;
      end else begin
         hard_resetn_o <= act_next;
         soft_resetn_o <= act_next && soft_next == '0;
         fetch_o <= act_next && !hard_resetn_o;
         rtc_tick_o <= osc_t[OSC32];
         osc_en_o <= osc_on;
         pll_en_o <= pll_on;
         pll_ref_o <= cfg_reg.pll_ref;
         pll_mul_o <= cfg_reg.pll_mul;
         status_o <= '{osc_rdy: osc_rdy, pll_ok: pll_ok};
      end
   end
   assign boot_addr_o = RESET_ADDR;
   assign reset_cause_o = cause_reg;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!resetn_i);

   sequence s_settle;
      state_reg == ST_POR && pwr_s && cnt_reg == POR_LAST;
   endsequence
   sequence s_held;
      !hard_resetn_o [*2];
   endsequence

   a_por_hold: assert property (!pwr_s |=> !hard_resetn_o)
      else $error("reset not held while power unstable");
   a_por_stretch: assert property (s_settle |=> s_held)
      else $error("reset released straight after power settled");
   a_boot_defaults: assert property ($rose(hard_resetn_o) |->
      cfg_reg.pll_en == '0 && !cfg_reg.cpu_div.en && &pba_mask_reg)
      else $error("start-up clock setting wrong");
   a_boot_fetch: assert property (fetch_o |-> hard_resetn_o &&
      $past(!hard_resetn_o) && boot_addr_o == RESET_ADDR)
      else $error("fetch not at release or wrong address");
   a_domain_root: assert property (pba_clk_en_o[0] |-> $past(main_t))
      else $error("domain tick without main clock");
   a_fly_change: assert property (cfg_wr_i && state_reg == ST_RUN &&
      pwr_s && !hard_src |=> cfg_reg == $past(cfg_i) && hard_resetn_o)
      else $error("setting change disturbed the system");
   a_mod_gate: assert property (!hsb_mask_reg[0] |=> !hsb_clk_en_o[0])
      else $error("gated module clock ran");
   a_sleep_stop: assert property (sleeping && slp_reg.stop_cpu
      |=> !cpu_clk_en_o)
      else $error("cpu clock ran in sleep");
   a_wake_up: assert property (sleeping && wake && pwr_s &&
      !hard_src |=> state_reg == ST_RUN)
      else $error("interrupt did not wake");
   a_cause_rec: assert property (state_reg == ST_RUN && pwr_s &&
      wdt_reset_i |=> reset_cause_o[RC_WDT] && !hard_resetn_o)
      else $error("watchdog reset not recorded");
   a_pll_ref: assert property (pll_ok[0] |->
      osc_rdy[cfg_reg.pll_ref[0]])
      else $error("pll usable without its reference");
   a_gclk_off: assert property (!gclk_cfg_i[0].en |=> !gclk_o[0])
      else $error("disabled generic clock ran");
   a_rtc_src: assert property (!osc_rdy[OSC32] |=> !rtc_tick_o)
      else $error("rtc tick from unready oscillator");
   a_osc_mask: assert property ($rose(osc_on[0]) |=>
      !status_o.osc_rdy[0] [*8])
      else $error("oscillator ready during start-up");
   a_pll_mask: assert property (cfg_reg.main_sel == MSEL_PLL0 &&
      !lock_s[0] |-> !main_t)
      else $error("unlocked pll clocked logic");
   a_slow_default: assert property ($rose(hard_resetn_o) |->
      cfg_reg.main_sel == MSEL_SLOW)
      else $error("main clock not on slow clock after reset");
endmodule // bcm_manager
`default_nettype wire

//--- bcm_pin_model.sv
// Model of the oscillator, PLL and lock pins around the manager
// Assumes pins move only at rising edges of the fast sampling clock
`timescale 1ns/1ps
`default_nettype none
module bcm_pin_model #(
   parameter int RC_HALF = 4,
   parameter int LOCK_CYC = 40
) (
   input wire logic clock_i,
   input wire logic [bcm_pkg::NOSC-1:0] osc_en_i,
   input wire logic [bcm_pkg::NPLL-1:0] pll_en_i,
   output logic rc_clk_o,
   output logic [bcm_pkg::NOSC-1:0] osc_clk_o,
   output logic [bcm_pkg::NPLL-1:0] pll_clk_o,
   output logic [bcm_pkg::NPLL-1:0] pll_lock_o
);
   import bcm_pkg::*;
   localparam int HALF [6] = '{5, 6, 16, 2, 3, RC_HALF};
   logic [5:0] pin = '0;
   logic [5:0] run;
   int cnt [6] = '{default: 0};
   int lock_cnt [NPLL] = '{default: 0};
   assign run = {1'b1, pll_en_i, osc_en_i};
   assign rc_clk_o = pin[5];
   assign osc_clk_o = pin[2:0];
   assign pll_clk_o = pin[4:3];
   always @(posedge clock_i) begin
      for (int i = 0; i < 6; i++) begin
         if (!run[i]) begin
            // A stopped source stands still low
            pin[i] <= 1'b0;
            cnt[i] <= 0;
         end else if (cnt[i] == HALF[i] - 1) begin
            pin[i] <= ~pin[i];
            cnt[i] <= 0;
         end else begin
            cnt[i] <= cnt[i] + 1;
         end
      end
      for (int j = 0; j < NPLL; j++) begin
         lock_cnt[j] <= pll_en_i[j] ? lock_cnt[j] + 1 : 0;
      end
   end
   always_comb begin
      for (int j = 0; j < NPLL; j++) begin
         pll_lock_o[j] = lock_cnt[j] >= LOCK_CYC;
      end
   end
endmodule // bcm_pin_model
`default_nettype wire

//--- tb_bcm_manager.sv
// Self-checking bench of the boot, clock and reset manager
// Assumes bcm_pin_model drives the pins; inputs move on the falling edge
`timescale 1ns/1ps
`default_nettype none
module tb_bcm_manager;
   import bcm_pkg::*;
   localparam int OSC_S = 16;
   logic clock_i = 1'b0;
   logic resetn_i = 1'b0;
   logic power_ok_i = 1'b0;
   logic ext_resetn_i = 1'b1;
   logic bod_reset_i = 1'b0;
   logic wdt_reset_i = 1'b0;
   logic soft_reset_i = 1'b0;
   logic ext_irq_i = 1'b0;
   logic irq_i = 1'b0;
   logic sleep_i = 1'b0;
   bcm_sleep_s sleep_cfg_i = '0;
   logic cfg_wr_i = 1'b0;
   bcm_cfg_s cfg_i = CFG_RST;
   bcm_cfg_s cfg = CFG_RST;
   logic [3:0] hsb_mask_i = '1;
   logic [7:0] pba_mask_i = '1;
   logic [3:0] pbb_mask_i = '1;
   bcm_gclk_s [1:0] gclk_cfg_i = '0;
   logic cause_clr_i = 1'b0;
   logic rc_clk_i;
   logic [NOSC-1:0] osc_clk_i;
   logic [NPLL-1:0] pll_clk_i;
   logic [NPLL-1:0] pll_lock_i;
   logic hard_resetn_o, soft_resetn_o, fetch_o, cpu_clk_en_o, rtc_tick_o;
   logic [31:0] boot_addr_o;
   logic [3:0] hsb_clk_en_o;
   logic [7:0] pba_clk_en_o;
   logic [3:0] pbb_clk_en_o;
   logic [1:0] gclk_o, gclk_q = '0;
   logic [NOSC-1:0] osc_en_o;
   logic [NPLL-1:0] pll_en_o, pll_ref_o;
   logic [NPLL-1:0][7:0] pll_mul_o;
   bcm_status_s status_o;
   logic [NRC-1:0] reset_cause_o;
   logic [2:0] pin_q = '0;
   int cnt [11] = '{default: 0};
   int m [11];
   int num_errors = 0;
   int n_compared = 0;

   bcm_manager #(.OSC_START(OSC_S)) dut (.clock_i(clock_i),
      .resetn_i(resetn_i), .power_ok_i(power_ok_i),
      .ext_resetn_i(ext_resetn_i), .bod_reset_i(bod_reset_i),
      .wdt_reset_i(wdt_reset_i), .soft_reset_i(soft_reset_i),
      .rc_clk_i(rc_clk_i), .osc_clk_i(osc_clk_i), .pll_clk_i(pll_clk_i),
      .pll_lock_i(pll_lock_i), .ext_irq_i(ext_irq_i), .irq_i(irq_i),
      .sleep_i(sleep_i), .sleep_cfg_i(sleep_cfg_i), .cfg_wr_i(cfg_wr_i),
      .cfg_i(cfg_i), .hsb_mask_i(hsb_mask_i), .pba_mask_i(pba_mask_i),
      .pbb_mask_i(pbb_mask_i), .gclk_cfg_i(gclk_cfg_i),
      .cause_clr_i(cause_clr_i), .hard_resetn_o(hard_resetn_o),
      .soft_resetn_o(soft_resetn_o), .fetch_o(fetch_o),
      .boot_addr_o(boot_addr_o), .cpu_clk_en_o(cpu_clk_en_o),
      .hsb_clk_en_o(hsb_clk_en_o), .pba_clk_en_o(pba_clk_en_o),
      .pbb_clk_en_o(pbb_clk_en_o), .gclk_o(gclk_o),
      .rtc_tick_o(rtc_tick_o), .osc_en_o(osc_en_o), .pll_en_o(pll_en_o),
      .pll_ref_o(pll_ref_o), .pll_mul_o(pll_mul_o), .status_o(status_o),
      .reset_cause_o(reset_cause_o));
   bcm_pin_model pins (.clock_i(clock_i), .osc_en_i(osc_en_o),
      .pll_en_i(pll_en_o), .rc_clk_o(rc_clk_i), .osc_clk_o(osc_clk_i),
      .pll_clk_o(pll_clk_i), .pll_lock_o(pll_lock_i));

   always #2.5 clock_i = ~clock_i;

   // Event counters: pin edges, domain ticks, leaks through masks
   always @(posedge clock_i) begin
      pin_q <= {osc_clk_i[2], osc_clk_i[0], rc_clk_i};
      gclk_q <= gclk_o;
      if (rc_clk_i && !pin_q[0]) cnt[0] <= cnt[0] + 1;
      if (cpu_clk_en_o === 1'b1) cnt[1] <= cnt[1] + 1;
      if (pba_clk_en_o[0] === 1'b1) cnt[2] <= cnt[2] + 1;
      if (pba_clk_en_o === 8'hff) cnt[3] <= cnt[3] + 1;
      if ((|(hsb_clk_en_o & ~hsb_mask_i)) || (|(pba_clk_en_o & ~pba_mask_i))
          || (|(pbb_clk_en_o & ~pbb_mask_i))) cnt[4] <= cnt[4] + 1;
      if (osc_clk_i[0] && !pin_q[1]) cnt[5] <= cnt[5] + 1;
      if (osc_clk_i[2] && !pin_q[2]) cnt[6] <= cnt[6] + 1;
      if (rtc_tick_o === 1'b1) cnt[7] <= cnt[7] + 1;
      if (gclk_o[0] !== gclk_q[0]) cnt[8] <= cnt[8] + 1;
      if (pbb_clk_en_o[0] === 1'b1) cnt[9] <= cnt[9] + 1;
      if (gclk_o[1] !== gclk_q[1]) cnt[10] <= cnt[10] + 1;
   end

   function automatic int ratio(input logic [2:0] sel);
      return 1 << (sel + 1);
   endfunction

   task automatic finish_test;
      if (num_errors == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic near(input int got, input int exp, input int tol);
      n_compared++;
      if (got < exp - tol || got > exp + tol) begin
         num_errors++;
         $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic measure(input int n, output int d [11]);
      int s [11];
      s = cnt;
      repeat (n) @(negedge clock_i);
      foreach (d[i]) d[i] = cnt[i] - s[i];
   endtask

   task automatic wr_cfg;
      @(negedge clock_i);
      cfg_i = cfg;
      cfg_wr_i = 1'b1;
      @(negedge clock_i);
      cfg_wr_i = 1'b0;
   endtask

   task automatic wait_hard(output int n);
      n = 0;
      while (hard_resetn_o !== 1'b1 && n < 2000) begin
         @(negedge clock_i);
         n++;
      end
   endtask

   initial begin
      #(400_000);
      num_errors++;
      finish_test();
   end

   initial begin
      int n;
      int r;
      int d;
      r = $urandom(72304);
      repeat (5) @(negedge clock_i);
      check(hard_resetn_o, 0);
      check(boot_addr_o, RESET_ADDR);
      resetn_i = 1'b1;
      repeat (30) @(negedge clock_i);
      check(hard_resetn_o, 0);
      power_ok_i = 1'b1;
      wait_hard(n);
      near(n, POR_SETTLE_CYC + RST_STRETCH_CYC + 2, 3);
      check(fetch_o, 1);
      check(reset_cause_o, 5'h01);
      @(negedge clock_i);
      check(fetch_o, 0);
      check({pll_en_o, osc_en_o}, 0);
      measure(1024, m);
      near(m[1], m[0], 1);
      near(m[3], m[0], 1);
      // Prescaler taps 0 to 2 with random module masks, changed while running
      for (int s = 0; s < 3; s++) begin
         cfg.pba_div = '{en: 1'b1, sel: 3'(2 - s)};
         cfg.pbb_div = '{en: 1'b1, sel: 3'(s)};
         hsb_mask_i = {3'($urandom), 1'(s)};
         pba_mask_i = 8'($urandom) | 8'h01;
         pbb_mask_i = 4'($urandom) | 4'h1;
         wr_cfg();
         repeat (4) @(negedge clock_i);
         measure(1024, m);
         near(m[2], m[1] / ratio(3'(2 - s)), 1);
         near(m[9], m[1] / ratio(3'(s)), 1);
         check(m[4], 0);
      end
      cfg.osc_en = 3'h7;
      wr_cfg();
      n = 0;
      while (status_o.osc_rdy[0] !== 1'b1 && n < 200) begin
         @(negedge clock_i);
         n++;
      end
      near(n, OSC_S, 3);
      repeat (4) @(negedge clock_i);
      d = $urandom_range(0, 3);
      gclk_cfg_i[0] = '{en: 1'b1, src: 2'h0, div: 8'(d)};
      gclk_cfg_i[1] = '{en: 1'b1, src: 2'h2, div: 8'h00};
      cfg.main_sel = MSEL_OSC0;
      wr_cfg();
      repeat (8) @(negedge clock_i);
      measure(1024, m);
      near(m[7], m[6], 1);
      near(m[1], m[5], 1);
      near(m[8], m[5] / (d + 1), 1);
      cfg.pll_en = 2'h1;
      cfg.pll_ref = 2'($urandom);
      cfg.pll_mul[0] = 8'($urandom);
      wr_cfg();
      measure(2, m);
      check(pll_en_o, 2'h1);
      check(pll_ref_o, cfg.pll_ref);
      check(pll_mul_o[0], cfg.pll_mul[0]);
      check(status_o.pll_ok[0], 0);
      measure(30, m);
      check(m[10], 0);
      measure(200, m);
      check(status_o.pll_ok[0], 1);
      check(m[10] > 0, 1);
      // Main clock on the PLL, then the PLL dropped and brought back
      cfg.main_sel = MSEL_PLL0;
      wr_cfg();
      measure(256, m);
      near(m[1], m[10], 1);
      cfg.pll_en = 2'h0;
      wr_cfg();
      @(negedge clock_i);
      measure(256, m);
      check(m[1], 0);
      cfg.pll_en = 2'h1;
      wr_cfg();
      measure(200, m);
      check(m[1] > 0, 1);
      sleep_cfg_i = '{stop_cpu: 1'b1, stop_pba: 1'b1, default: 1'b0};
      for (int k = 0; k < 2; k++) begin
         sleep_i = 1'b1;
         @(negedge clock_i);
         sleep_i = 1'b0;
         @(negedge clock_i);
         measure(256, m);
         check(m[1], 0);
         check(m[2], 0);
         check(m[9] > 0, 1);
         irq_i = (k == 0);
         ext_irq_i = (k == 1);
         repeat (4) @(negedge clock_i);
         irq_i = 1'b0;
         ext_irq_i = 1'b0;
         measure(256, m);
         check(m[1] > 0, 1);
      end
      cause_clr_i = 1'b1;
      @(negedge clock_i);
      cause_clr_i = 1'b0;
      @(negedge clock_i);
      check(reset_cause_o, 0);
      soft_reset_i = 1'b1;
      @(negedge clock_i);
      soft_reset_i = 1'b0;
      n = 0;
      while (soft_resetn_o !== 1'b1 && n < 100) begin
         @(negedge clock_i);
         n++;
      end
      near(n, SOFT_RST_CYC, 2);
      check({hard_resetn_o, reset_cause_o}, 6'h30);
      for (int i = RC_EXT; i <= RC_BOD; i++) begin
         ext_resetn_i = (i != RC_EXT);
         wdt_reset_i = (i == RC_WDT);
         bod_reset_i = (i == RC_BOD);
         repeat (4) @(negedge clock_i);
         check({hard_resetn_o, reset_cause_o}, 6'h01 << i);
         ext_resetn_i = 1'b1;
         wdt_reset_i = 1'b0;
         bod_reset_i = 1'b0;
         wait_hard(n);
         near(n, RST_STRETCH_CYC + 2, 4);
         check(pll_en_o, 0);
      end
      measure(1024, m);
      near(m[1], m[0], 1);
      power_ok_i = 1'b0;
      repeat (6) @(negedge clock_i);
      check(hard_resetn_o, 0);
      power_ok_i = 1'b1;
      wait_hard(n);
      near(n, POR_SETTLE_CYC + RST_STRETCH_CYC + 2, 3);
      check(reset_cause_o, 5'h01);
      finish_test();
   end
endmodule // tb_bcm_manager
`default_nettype wire
